/* File: rtl/input_map_pkg.sv */
// Constants, types and encodings for the input function mapper.
// Assumes a single 100 MHz clock domain and an APB register master.
// What this block does
// - Function assignments are captured at every reset release.
// - Each hardware input carries one function picked by its number.
// - Sixteen virtual inputs take levels from a software-written word.
// - Overtravel, halt, regen overheat are active-low on pins, high virtually.
// - Drive-energize inactive disables gates, coasts, ignores rotation commands.
// - Energize dropping while turning starts a stop chosen by a setting.
// - Ready needs no alarm, energize active and halt not stopping.
// - Unassigned drive-energize counts as always active.
// - Run positive or negative keeps rotation in that direction.
// - Run input rising edge accelerates, falling edge decelerates.
// - Unassigned run or positioning-start counts as always inactive.
// - Positioning start only honoured in positioning control mode.
// - Positioning move starts on inactive-to-active start edge.
// - Table mode takes the move from the four destination-select bits.
// - Without table mode the move comes from serially written targets.
// - Positioning-complete drops as soon as a started move rotates.
// - Unassigned emergency halt counts as not stopping.
package input_map_pkg;

	localparam int HW_INPUTS   = 8;
	localparam int COMM_INPUTS = 16;
	localparam int ALL_INPUTS  = 24;
	localparam int FUNC_W      = 7;

	// Function numbers.
	localparam logic [6:0] FN_NONE         = 7'h00;
	localparam logic [6:0] FN_ENERGIZE     = 7'h01;
	localparam logic [6:0] FN_RUN_POS      = 7'h02;
	localparam logic [6:0] FN_RUN_NEG      = 7'h03;
	localparam logic [6:0] FN_POS_START    = 7'h04;
	localparam logic [6:0] FN_OT_PLUS      = 7'h07;
	localparam logic [6:0] FN_OT_MINUS     = 7'h08;
	localparam logic [6:0] FN_EMERG_HALT   = 7'h0A;
	localparam logic [6:0] FN_ALARM_RESET  = 7'h0B;
	localparam logic [6:0] FN_REGEN_HOT    = 7'h22;
	localparam logic [6:0] FN_INT_ENABLE   = 7'h30;
	localparam logic [6:0] FN_DEST_BIT0    = 7'h3C;
	localparam logic [6:0] FN_DEST_BIT1    = 7'h3D;
	localparam logic [6:0] FN_DEST_BIT2    = 7'h3E;
	localparam logic [6:0] FN_DEST_BIT3    = 7'h3F;

	// Assignment reset values for inputs 1 and 2, others zero.
	localparam logic [6:0] ASSIGN1_RESET = 7'h01;
	localparam logic [6:0] ASSIGN2_RESET = 7'h0B;

	localparam logic [3:0] MODE_POSITIONING = 4'h7;

	// Register byte offsets.
	localparam logic [11:0] OFS_ASSIGN_BASE = 12'h000; // 24 words
	localparam logic [11:0] OFS_COMM_IN     = 12'h060;
	localparam logic [11:0] OFS_CONFIG      = 12'h064;
	localparam logic [11:0] OFS_TARGET_POS  = 12'h068;
	localparam logic [11:0] OFS_TARGET_SPD  = 12'h06C;
	localparam logic [11:0] OFS_STATUS      = 12'h070;
	localparam logic [11:0] OFS_FUNC_LEVELS = 12'h074;
	localparam logic [11:0] OFS_ACTIVE_MAP  = 12'h078;

	// Config field positions.
	localparam int CFG_MODE_LSB   = 0;
	localparam int CFG_TABLE_BIT  = 4;
	localparam int CFG_STOP_LSB   = 5;
	localparam int CFG_ALARM_BIT  = 7;
	localparam int CFG_MOVING_BIT = 8;
	localparam int CFG_DONE_BIT   = 9;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

	typedef struct packed {
		logic       energize;
		logic       run_pos;
		logic       run_neg;
		logic       pos_start;
		logic       ot_plus;
		logic       ot_minus;
		logic       emerg_halt;
		logic       alarm_reset;
		logic       regen_hot;
		logic       int_enable;
		logic [3:0] dest_index;
	} func_levels_t;

	typedef struct packed {
		logic        gate_enable;
		logic        ready;
		logic        stopping;
		logic [1:0]  stop_profile;
		logic        accel_pos;
		logic        accel_neg;
		logic        decel;
		logic        rotate_pos;
		logic        rotate_neg;
		logic        move_start;
		logic        move_from_table;
		logic [3:0]  move_index;
		logic [31:0] move_pos;
		logic [31:0] move_spd;
		logic        pos_complete;
	} motion_cmd_t;

	typedef enum logic [1:0] {
		MOTION_IDLE,
		MOTION_RUN,
		MOTION_STOP
	} motion_state_t;

endpackage

/* File: rtl/input_function_mapper.sv */
// Input function mapper: routes 8 pins and 16 software inputs to functions.
// Assumes an APB master on ref_clk and pins asynchronous to ref_clk.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module input_function_mapper
(
	input  wire logic                             ref_clk,
	input  wire logic                             reset,
	input  wire logic                             clk_en,
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [11:0]                      paddr,
	input  wire logic [31:0]                      pwdata,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	input  wire logic [input_map_pkg::HW_INPUTS-1:0] configurable_input,
	input  wire logic                             motor_turning,
	output input_map_pkg::motion_cmd_t            motion_cmd
);

	localparam int N  = input_map_pkg::ALL_INPUTS;
	localparam int NH = input_map_pkg::HW_INPUTS;

	////////////////////////////////////////////////////////////////////////
	// Assignment settings: a shadow that software writes, and the live copy
	// taken once after reset release so edits only act after the next reset.

	logic [6:0]  shadow_assign [N];
	logic [6:0]  live_assign   [N];
	logic        captured;
	logic [15:0] comm_word;
	logic [31:0] config_reg;
	logic [31:0] target_pos;
	logic [31:0] target_spd;

	wire        access   = psel && penable && clk_en;
	wire        wr_en    = access && pwrite;
	wire [9:0]  word_idx = paddr[11:2];
	wire        in_table = (paddr < 12'(N * 4));

	generate
		for (genvar i = 0; i < N; i++)
		begin : g_assign
			localparam logic [6:0] RST_VAL =
				(i == 0) ? input_map_pkg::ASSIGN1_RESET :
				(i == 1) ? input_map_pkg::ASSIGN2_RESET :
				input_map_pkg::FN_NONE;
			logic [6:0] stored = RST_VAL;
			wire hit = wr_en && in_table && (word_idx == 10'(i));
			// No reset here: the settings stand for non-volatile storage and
			// must outlive a reset, so an edit takes effect at the next reset release.
			always_ff @(posedge ref_clk)
			begin
				if (hit)
					stored <= pwdata[6:0];
			end
			assign shadow_assign[i] = stored;
			always_ff @(posedge ref_clk or posedge reset)
			begin
				if (reset)
					live_assign[i] <= input_map_pkg::FN_NONE;
				else if (clk_en && !captured)
					live_assign[i] <= shadow_assign[i];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			captured <= 1'b0;
		else if (clk_en)
			captured <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser: three stages, a change counts once stages two and
	// three agree, so a metastable first stage never reaches the logic.

	logic [NH-1:0] sync1;
	logic [NH-1:0] sync2;
	logic [NH-1:0] sync3;
	logic [NH-1:0] pin_level;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sync1     <= '0;
			sync2     <= '0;
			sync3     <= '0;
			pin_level <= '0;
		end
		else if (clk_en)
		begin
			sync1 <= configurable_input;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_level <= (sync2 & sync3) | (pin_level & (sync2 | sync3));
		end
	end

	wire [N-1:0] raw_level = {comm_word, pin_level};

	////////////////////////////////////////////////////////////////////////
	// Function decode. Safety inputs read inverted on pins (break contact)
	// and straight on virtual inputs, so a broken wire stops the axis.

	function automatic logic is_break_fn(input logic [6:0] fn);
		return fn == input_map_pkg::FN_OT_PLUS
			|| fn == input_map_pkg::FN_OT_MINUS
			|| fn == input_map_pkg::FN_EMERG_HALT
			|| fn == input_map_pkg::FN_REGEN_HOT;
	endfunction

	logic [N-1:0] eff_level;
	generate
		for (genvar i = 0; i < N; i++)
		begin : g_pol
			assign eff_level[i] = (i < NH && is_break_fn(live_assign[i]))
				? !raw_level[i] : raw_level[i];
		end
	endgenerate

	function automatic logic [1:0] lookup(
		input logic [6:0] fn,
		input logic [N-1:0] lvl,
		input logic [6:0] map [N]);
		logic [1:0] r;
		r = 2'b00;
		for (int k = 0; k < N; k++)
			if (map[k] == fn)
				r = {1'b1, r[0] | lvl[k]};
		return r; // {assigned, active}
	endfunction

	wire [1:0] f_en  = lookup(input_map_pkg::FN_ENERGIZE, eff_level, live_assign);
	wire [1:0] f_rp  = lookup(input_map_pkg::FN_RUN_POS, eff_level, live_assign);
	wire [1:0] f_rn  = lookup(input_map_pkg::FN_RUN_NEG, eff_level, live_assign);
	wire [1:0] f_st  = lookup(input_map_pkg::FN_POS_START, eff_level, live_assign);
	wire [1:0] f_otp = lookup(input_map_pkg::FN_OT_PLUS, eff_level, live_assign);
	wire [1:0] f_otn = lookup(input_map_pkg::FN_OT_MINUS, eff_level, live_assign);
	wire [1:0] f_eh  = lookup(input_map_pkg::FN_EMERG_HALT, eff_level, live_assign);
	wire [1:0] f_ar  = lookup(input_map_pkg::FN_ALARM_RESET, eff_level, live_assign);
	wire [1:0] f_rh  = lookup(input_map_pkg::FN_REGEN_HOT, eff_level, live_assign);
	wire [1:0] f_ie  = lookup(input_map_pkg::FN_INT_ENABLE, eff_level, live_assign);
	wire [1:0] f_d0  = lookup(input_map_pkg::FN_DEST_BIT0, eff_level, live_assign);
	wire [1:0] f_d1  = lookup(input_map_pkg::FN_DEST_BIT1, eff_level, live_assign);
	wire [1:0] f_d2  = lookup(input_map_pkg::FN_DEST_BIT2, eff_level, live_assign);
	wire [1:0] f_d3  = lookup(input_map_pkg::FN_DEST_BIT3, eff_level, live_assign);

	input_map_pkg::func_levels_t fl;
	assign fl.energize    = f_en[1] ? f_en[0] : 1'b1;
	assign fl.run_pos     = f_rp[0];
	assign fl.run_neg     = f_rn[0];
	assign fl.pos_start   = f_st[0];
	assign fl.ot_plus     = f_otp[0];
	assign fl.ot_minus    = f_otn[0];
	// Halt is stored as "stopping", so unassigned means not stopping.
	assign fl.emerg_halt  = f_eh[0];
	assign fl.alarm_reset = f_ar[0];
	assign fl.regen_hot   = f_rh[0];
	assign fl.int_enable  = f_ie[0];
	assign fl.dest_index  = {f_d3[0], f_d2[0], f_d1[0], f_d0[0]};

	////////////////////////////////////////////////////////////////////////
	// Motion sequencing.

	input_map_pkg::func_levels_t prev_fl;
	input_map_pkg::motion_state_t state;
	input_map_pkg::motion_state_t next_state;
	logic prev_turning;

	wire [3:0] ctl_mode = config_reg[input_map_pkg::CFG_MODE_LSB +: 4];
	wire       tbl_sel  = config_reg[input_map_pkg::CFG_TABLE_BIT];
	wire       alarm    = config_reg[input_map_pkg::CFG_ALARM_BIT];
	// Nothing may act before the live assignments are taken, since an
	// empty map reads as energized and would briefly open the gates.
	wire       ready    = captured && !alarm && fl.energize
		&& !fl.emerg_halt;
	wire       pos_mode = (ctl_mode == input_map_pkg::MODE_POSITIONING);
	wire       start_edge = ready && pos_mode
		&& fl.pos_start && !prev_fl.pos_start;
	wire       drop_while_turning = !fl.energize && prev_fl.energize
		&& motor_turning;

	always_comb
	begin
		next_state = state;
		case (state)
			input_map_pkg::MOTION_IDLE:
				if (drop_while_turning)
					next_state = input_map_pkg::MOTION_STOP;
				else if (start_edge)
					next_state = input_map_pkg::MOTION_RUN;
			input_map_pkg::MOTION_RUN:
				if (drop_while_turning)
					next_state = input_map_pkg::MOTION_STOP;
				else if (!ready || (prev_turning && !motor_turning))
					next_state = input_map_pkg::MOTION_IDLE;
			input_map_pkg::MOTION_STOP:
				if (!motor_turning)
					next_state = input_map_pkg::MOTION_IDLE;
			default:
				next_state = input_map_pkg::MOTION_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state        <= input_map_pkg::MOTION_IDLE;
			prev_fl      <= '0;
			prev_turning <= 1'b0;
		end
		else if (clk_en)
		begin
			state        <= next_state;
			prev_fl      <= captured ? fl : '0;
			prev_turning <= motor_turning;
		end
	end

	input_map_pkg::motion_cmd_t next_cmd;
	always_comb
	begin
		next_cmd                 = motion_cmd;
		next_cmd.gate_enable     = captured && fl.energize;
		next_cmd.ready           = ready;
		next_cmd.stopping        = (next_state == input_map_pkg::MOTION_STOP)
			|| (motion_cmd.stopping && motor_turning);
		next_cmd.stop_profile    =
			config_reg[input_map_pkg::CFG_STOP_LSB +: 2];
		next_cmd.rotate_pos      = ready && fl.run_pos;
		next_cmd.rotate_neg      = ready && fl.run_neg;
		next_cmd.accel_pos       = ready && fl.run_pos && !prev_fl.run_pos;
		next_cmd.accel_neg       = ready && fl.run_neg && !prev_fl.run_neg;
		next_cmd.decel           = (prev_fl.run_pos && !fl.run_pos)
			|| (prev_fl.run_neg && !fl.run_neg);
		next_cmd.move_start      = start_edge;
		if (start_edge)
		begin
			next_cmd.move_from_table = tbl_sel;
			next_cmd.move_index      = fl.dest_index;
			next_cmd.move_pos        = target_pos;
			next_cmd.move_spd        = target_spd;
		end
		if (state == input_map_pkg::MOTION_RUN && motor_turning)
			next_cmd.pos_complete = 1'b0;
		else if (state != input_map_pkg::MOTION_RUN)
			next_cmd.pos_complete = 1'b1;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			motion_cmd              <= '0;
			motion_cmd.pos_complete <= 1'b1;
		end
		else if (clk_en)
			motion_cmd <= next_cmd;
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, unmapped addresses read zero with error.

	wire hit_comm = paddr == input_map_pkg::OFS_COMM_IN;
	wire hit_cfg  = paddr == input_map_pkg::OFS_CONFIG;
	wire hit_tpos = paddr == input_map_pkg::OFS_TARGET_POS;
	wire hit_tspd = paddr == input_map_pkg::OFS_TARGET_SPD;
	wire hit_stat = paddr == input_map_pkg::OFS_STATUS;
	wire hit_lvl  = paddr == input_map_pkg::OFS_FUNC_LEVELS;
	wire hit_map  = paddr == input_map_pkg::OFS_ACTIVE_MAP;
	wire mapped   = in_table || hit_comm || hit_cfg || hit_tpos
		|| hit_tspd || hit_stat || hit_lvl || hit_map;

	wire [31:0] status_word = {24'h00_0000, 1'b0,
		state == input_map_pkg::MOTION_RUN, motion_cmd.pos_complete,
		motion_cmd.stopping, motion_cmd.ready, motion_cmd.gate_enable,
		captured, ready};
	wire [31:0] rd_word =
		in_table ? {25'h000_0000, shadow_assign[word_idx[4:0]]} :
		hit_comm ? {16'h0000, comm_word} :
		hit_cfg  ? config_reg :
		hit_tpos ? target_pos :
		hit_tspd ? target_spd :
		hit_stat ? status_word :
		hit_lvl  ? {18'h0_0000, fl} :
		hit_map  ? {8'h00, eff_level} : 32'h0000_0000;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			comm_word  <= 16'h0000;
			config_reg <= input_map_pkg::CONFIG_RESET;
			target_pos <= 32'h0000_0000;
			target_spd <= 32'h0000_0000;
		end
		else if (wr_en)
		begin
			if (hit_comm)
				comm_word <= pwdata[15:0];
			if (hit_cfg)
				config_reg <= {22'h00_0000, pwdata[9:0]};
			if (hit_tpos)
				target_pos <= pwdata;
			if (hit_tspd)
				target_spd <= pwdata;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? rd_word : prdata;
		end
	end

endmodule

/* File: testbench/mapper_checker_assertions.sv */
// Concurrent checks on the input function mapper, bound to its top module.
// Assumes the top module ports and the motion struct of the design package.
`timescale 1ns/1ps

module mapper_checker
(
	input logic                       ref_clk,
	input logic                       reset,
	input logic                       clk_en,
	input logic                       psel,
	input logic                       penable,
	input logic                       pready,
	input logic                       pslverr,
	input logic                       motor_turning,
	input input_map_pkg::motion_cmd_t motion_cmd
);

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////

	a_apb_answer: assert property (psel && !penable && clk_en |=> pready)
		else $error("no bus answer after setup");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	a_ready_gate: assert property (motion_cmd.ready |-> motion_cmd.gate_enable)
		else $error("ready while gate drive is off");
	// Rotation is registered in the same stage as ready, so it never trails ready.
	a_rotate_ready: assert property ((motion_cmd.rotate_pos ||
		motion_cmd.rotate_neg) |-> motion_cmd.ready || $past(motion_cmd.ready))
		else $error("rotation without ready");
	a_accel_pulse: assert property (motion_cmd.accel_pos |=> !motion_cmd.accel_pos)
		else $error("acceleration pulse too long");
	a_start_pulse: assert property (motion_cmd.move_start |=> !motion_cmd.move_start)
		else $error("start pulse repeated on level");
	a_start_ready: assert property (motion_cmd.move_start |->
		motion_cmd.ready || $past(motion_cmd.ready))
		else $error("move started while not ready");
	a_done_drops: assert property (motion_cmd.move_start ##1
		motor_turning [*3] |-> !motion_cmd.pos_complete)
		else $error("complete still high while moving");
	a_stop_cause: assert property ($rose(motion_cmd.stopping) |->
		$past(motor_turning))
		else $error("stop without rotation");
	a_stop_hold: assert property (motion_cmd.stopping && motor_turning |=>
		motion_cmd.stopping)
		else $error("stop released while turning");

	c_start: cover property (motion_cmd.move_start);
	c_stop: cover property (motion_cmd.stopping);
	c_accel: cover property (motion_cmd.accel_pos);
	c_refuse: cover property (pslverr);

endmodule

bind input_function_mapper mapper_checker mapper_checker_i
(
	.ref_clk(ref_clk),
	.reset(reset),
	.clk_en(clk_en),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.motor_turning(motor_turning),
	.motion_cmd(motion_cmd)
);

/* File: testbench/contact_bank.sv */
// Switch contacts and the controller hand that presses positioning start.
// Assumes the bench changes contact levels just after a rising edge.
`timescale 1ns/1ps

module contact_bank
#(
	parameter int START_PIN = 3
)
(
	input  logic       ref_clk,
	input  logic [7:0] closed,
	input  logic       start_req,
	input  logic       pos_complete,
	output logic [7:0] configurable_input
);

	logic pressed = 1'b0;

	// A request made while a move is running waits rather than pressing.
	always @(posedge ref_clk)
	begin
		if (!start_req)
			pressed <= 1'b0;
		else if (pos_complete)
			pressed <= 1'b1;
	end

	assign configurable_input = closed | (8'(pressed) << START_PIN);

endmodule

/* File: testbench/test_input_function_mapper.sv */
// Self-checking bench for the input function mapper over APB and pins.
// Assumes register shadows of the assignments survive a reset.
`timescale 1ns/1ps

module test_input_function_mapper;

	localparam logic [11:0] A = input_map_pkg::OFS_ASSIGN_BASE;
	localparam logic [11:0] C = input_map_pkg::OFS_CONFIG;
	localparam logic [11:0] V = input_map_pkg::OFS_COMM_IN;

	logic                       ref_clk = 1'b0;
	logic                       reset = 1'b1;
	logic                       clk_en = 1'b1;
	logic                       psel = 1'b0;
	logic                       penable = 1'b0;
	logic                       pwrite = 1'b0;
	logic [11:0]                paddr = 12'h000;
	logic [31:0]                pwdata = 32'h0000_0000;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	logic [7:0]                 closed = 8'h00;
	logic                       start_req = 1'b0;
	logic [7:0]                 configurable_input;
	logic                       motor_turning = 1'b0;
	input_map_pkg::motion_cmd_t motion_cmd;
	logic [31:0]                rdata;
	logic                       rerr;
	int                         errors = 0;
	int                         check_count = 0;
	int                         n_acc = 0;
	int                         n_dec = 0;
	int                         n_start = 0;

	always #5 ref_clk = ~ref_clk;

	input_function_mapper input_function_mapper_i
	(
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.configurable_input(configurable_input),
		.motor_turning(motor_turning),
		.motion_cmd(motion_cmd)
	);

	contact_bank contact_bank_i
	(
		.ref_clk(ref_clk),
		.closed(closed),
		.start_req(start_req),
		.pos_complete(motion_cmd.pos_complete),
		.configurable_input(configurable_input)
	);

	// Each positive-acceleration, deceleration and move-start pulse is counted once.
	always @(posedge ref_clk)
	begin
		n_acc <= n_acc + int'(motion_cmd.accel_pos);
		n_dec <= n_dec + int'(motion_cmd.decel);
		n_start <= n_start + int'(motion_cmd.move_start);
	end

	////////////////////////////////////////////////////////////////////

	task automatic results();
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		chkw(32'(got), 32'(exp));
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chkw(rdata, exp);
	endtask

	task automatic asg(input int i, input logic [6:0] fn);
		wr(A + 12'(4 * i), {25'h0, fn});
	endtask

	task automatic do_reset();
		reset <= 1'b1;
		tick(10);
		reset <= 1'b0;
		tick(2);
	endtask

	////////////////////////////////////////////////////////////////////

	initial
	begin
		#100_000;
		errors++;
		results();
	end

	initial
	begin
		do_reset();
		rd(A, 32'h0000_0001);
		rd(A + 12'h004, 32'h0000_000B);
		rd(A + 12'h008, 32'h0000_0000);
		rd(12'h0FC, 32'h0000_0000);
		chkb(rerr, 1'b1);
		tick(8);
		chkb(motion_cmd.gate_enable, 1'b0);
		closed <= 8'h01;
		tick(8);
		chkb(motion_cmd.gate_enable, 1'b1);
		chkb(motion_cmd.ready, 1'b1);
		wr(C, 32'h0000_0080);
		tick(2);
		chkb(motion_cmd.ready, 1'b0);
		wr(C, 32'h0000_0040);
		motor_turning <= 1'b1;
		closed <= 8'h00;
		tick(8);
		chkb(motion_cmd.stopping, 1'b1);
		chkw(32'(motion_cmd.stop_profile), 32'h0000_0002);
		chkb(motion_cmd.gate_enable, 1'b0);
		motor_turning <= 1'b0;
		tick(4);
		chkb(motion_cmd.stopping, 1'b0);
		// Interrupt-input enable stays unassigned on every input.
		asg(0, input_map_pkg::FN_NONE);
		asg(2, input_map_pkg::FN_RUN_POS);
		asg(3, input_map_pkg::FN_POS_START);
		asg(4, input_map_pkg::FN_EMERG_HALT);
		asg(12, input_map_pkg::FN_EMERG_HALT);
		for (int k = 0; k < 4; k++)
			asg(8 + k, input_map_pkg::FN_DEST_BIT0 + 7'(k));
		closed <= 8'h04;
		tick(8);
		chkw(n_acc, 0);
		chkb(motion_cmd.gate_enable, 1'b0);
		closed <= 8'h00;
		do_reset();
		closed <= 8'h10;
		tick(8);
		chkb(motion_cmd.gate_enable, 1'b1);
		chkb(motion_cmd.ready, 1'b1);
		closed <= 8'h00;
		tick(8);
		chkb(motion_cmd.ready, 1'b0);
		closed <= 8'h10;
		wr(V, 32'h0000_0010);
		tick(8);
		chkb(motion_cmd.ready, 1'b0);
		wr(V, 32'h0000_0005);
		tick(8);
		chkb(motion_cmd.ready, 1'b1);
		closed <= 8'h14;
		tick(8);
		chkb(motion_cmd.rotate_pos, 1'b1);
		chkw(n_acc, 1);
		chkb(motion_cmd.rotate_neg, 1'b0);
		closed <= 8'h10;
		tick(8);
		chkb(motion_cmd.rotate_pos, 1'b0);
		chkw(n_dec, 1);
		wr(C, 32'h0000_0010);
		start_req <= 1'b1;
		tick(8);
		start_req <= 1'b0;
		tick(8);
		chkw(n_start, 0);
		wr(C, 32'h0000_0017);
		start_req <= 1'b1;
		// The motor answers the start pulse at once, so completion must fall.
		@(posedge ref_clk iff motion_cmd.move_start);
		motor_turning <= 1'b1;
		tick(2);
		chkw(n_start, 1);
		chkw(32'(motion_cmd.move_index), 32'h0000_0005);
		chkb(motion_cmd.move_from_table, 1'b1);
		chkb(motion_cmd.pos_complete, 1'b0);
		tick(8);
		chkw(n_start, 1);
		start_req <= 1'b0;
		motor_turning <= 1'b0;
		tick(8);
		chkb(motion_cmd.pos_complete, 1'b1);
		wr(input_map_pkg::OFS_TARGET_POS, 32'h1234_5678);
		wr(input_map_pkg::OFS_TARGET_SPD, 32'h0000_0400);
		wr(C, 32'h0000_0007);
		start_req <= 1'b1;
		tick(8);
		chkw(n_start, 2);
		chkb(motion_cmd.move_from_table, 1'b0);
		chkw(motion_cmd.move_pos, 32'h1234_5678);
		chkw(motion_cmd.move_spd, 32'h0000_0400);
		// With the clock enable low, an opened halt contact must not be seen.
		clk_en <= 1'b0;
		closed <= 8'h00;
		tick(8);
		chkb(motion_cmd.ready, 1'b1);
		clk_en <= 1'b1;
		tick(8);
		chkb(motion_cmd.ready, 1'b0);
		results();
	end

endmodule
